//--- rtl/memory_map_pkg.sv
// Constants, field positions and carrier types of the memory map decoder.
// Assumes one 50 MHz clock and a CPU that issues one access per cycle.
package memory_map_pkg;

  // ----------------------------------------------------------------------
  // Widths and address map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int RAM_BYTES = 32;
  localparam int SP_W = 5;

  localparam logic [9:0] IO_BASE = 10'h000;
  localparam logic [9:0] IO_TOP = 10'h01f;
  localparam logic [9:0] ROM_BASE = 10'h020;
  localparam logic [9:0] ROM_TOP = 10'h3ef;
  localparam logic [9:0] RAM_BASE = 10'h0e0;
  localparam logic [9:0] RAM_TOP = 10'h0ff;
  localparam logic [9:0] WDOG_ADDR = 10'h3f0;
  localparam logic [9:0] VEC_BASE = 10'h3f8;
  localparam logic [9:0] VEC_TOP = 10'h3ff;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [9:0] OFF_PORT_A_DATA = 10'h000;
  localparam logic [9:0] OFF_PORT_B_DATA = 10'h001;
  localparam logic [9:0] OFF_PORT_A_DIR = 10'h004;
  localparam logic [9:0] OFF_PORT_B_DIR = 10'h005;
  localparam logic [9:0] OFF_TIMER_SC = 10'h008;
  localparam logic [9:0] OFF_TIMER_COUNT = 10'h009;
  localparam logic [9:0] OFF_EXT_IRQ_SC = 10'h00a;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int TSC_OVF_FLAG = 7;
  localparam int TSC_PER_FLAG = 6;
  localparam int TSC_OVF_IE = 5;
  localparam int TSC_PER_IE = 4;
  localparam int TSC_OVF_CLR = 3;
  localparam int TSC_PER_CLR = 2;
  localparam int TSC_RATE_HI = 1;
  localparam int TSC_RATE_LO = 0;
  localparam int ISC_ENABLE = 7;
  localparam int ISC_FLAG = 3;
  localparam int ISC_CLR = 1;
  localparam int PORT_B_PINS = 2;

  localparam logic [1:0] RATE_RESET = 2'h3;
  localparam logic EXT_EN_RESET = 1'h1;
  localparam logic [4:0] SP_RESET = 5'h1f;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [9:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic push;
    logic pull;
    logic reset_sp;
    logic [7:0] wdata;
  } stack_req_t;

  typedef struct packed {
    logic [7:0] port_a_direction;
    logic [1:0] port_b_direction;
    logic overflow_flag;
    logic periodic_irq_flag;
    logic overflow_irq_enable;
    logic periodic_irq_enable;
    logic [1:0] rate_select;
    logic ext_irq_enable;
    logic ext_irq_flag;
    logic [7:0] timer_count_value;
    logic [4:0] sp;
    logic [7:0] rdata;
    logic [7:0] stack_rdata;
    logic watchdog_clear;
  } state_t;

endpackage

//--- rtl/stack_ram.sv
// Byte RAM in flip-flops with one write port and two read ports.
// Assumes the caller resolves write priority; contents keep no reset.
module stack_ram #(
  parameter int BYTES = 32,
  parameter int IDX_W = 5
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx_a,
  output logic [7:0] rd_data_a,
  input wire logic [IDX_W-1:0] rd_idx_b,
  output logic [7:0] rd_data_b
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] mem [BYTES];

  // A pointer that cannot reach every byte would leave storage stranded.
  if (BYTES != (1 << IDX_W))
  begin : g_size_check
    $error("stack_ram: BYTES must equal 2**IDX_W");
  end

  // User variables survive reset, so the array has no reset branch.
  always_ff @(posedge mclk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  assign rd_data_a = mem[rd_idx_a];
  assign rd_data_b = mem[rd_idx_b];

endmodule

//--- rtl/memory_map_io_decode.sv
// Address decoder and I/O register bank for a 1 Kbyte 8-bit CPU space.
// Assumes program memory outside answers rom_rdata in the same cycle.

module memory_map_io_decode (
  input wire logic mclk,
  input wire logic rst,
  input wire memory_map_pkg::cpu_req_t cpu,
  output logic [7:0] cpu_rdata,
  output logic [9:0] rom_addr,
  output logic rom_rd,
  input wire logic [7:0] rom_rdata,
  input wire memory_map_pkg::stack_req_t stack,
  output logic [9:0] stack_pointer,
  output logic [7:0] stack_rdata,
  input wire logic [7:0] port_a_pin_i,
  output logic [7:0] port_a_pin_o,
  output logic [7:0] port_a_pin_oe,
  input wire logic [1:0] port_b_pin_i,
  output logic [1:0] port_b_pin_o,
  output logic [1:0] port_b_pin_oe,
  input wire logic [7:0] timer_count_in,
  input wire logic timer_overflow_evt,
  input wire logic periodic_evt,
  input wire logic ext_irq_evt,
  output logic overflow_flag,
  output logic periodic_irq_flag,
  output logic overflow_irq_enable,
  output logic periodic_irq_enable,
  output logic [1:0] rate_select,
  output logic ext_irq_enable,
  output logic ext_irq_flag,
  output logic watchdog_clear
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic in_range(input logic [9:0] a,
                                    input logic [9:0] lo,
                                    input logic [9:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Output pins read back their latch, input pins their level.
  function automatic logic [7:0] pin_view(input logic [7:0] latch,
                                          input logic [7:0] dir,
                                          input logic [7:0] pin);
    pin_view = (latch & dir) | (pin & ~dir);
  endfunction

  memory_map_pkg::state_t r;
  memory_map_pkg::state_t next_r;
  logic [7:0] port_a_data;
  logic [1:0] port_b_data;
  logic sel_io;
  logic sel_ram;
  logic sel_rom;
  logic [7:0] io_rdata;
  logic [7:0] ram_cpu_rdata;
  logic [7:0] ram_stk_rdata;
  logic ram_wr_en;
  logic [4:0] ram_wr_idx;
  logic [7:0] ram_wr_data;
  logic [4:0] sp_inc;
  logic [4:0] sp_dec;
  logic io_wr;
  logic wdog_hit;
  logic wr_port_a;
  logic wr_port_b;

  // The watchdog byte and vectors remain program memory for reads.
  assign sel_io = in_range(cpu.addr, memory_map_pkg::IO_BASE,
                           memory_map_pkg::IO_TOP);
  assign sel_ram = in_range(cpu.addr, memory_map_pkg::RAM_BASE,
                            memory_map_pkg::RAM_TOP);
  assign sel_rom = !sel_ram &&
    (in_range(cpu.addr, memory_map_pkg::ROM_BASE, memory_map_pkg::ROM_TOP)
     || in_range(cpu.addr, memory_map_pkg::VEC_BASE,
                 memory_map_pkg::VEC_TOP)
     || wdog_hit);
  assign io_wr = cpu.wr && sel_io;
  assign wdog_hit = cpu.addr == memory_map_pkg::WDOG_ADDR;

  // Port latches load only on a write that names their own offset.
  assign wr_port_a = io_wr && cpu.addr == memory_map_pkg::OFF_PORT_A_DATA;
  assign wr_port_b = io_wr && cpu.addr == memory_map_pkg::OFF_PORT_B_DATA;

  // Program memory is only ever read; writes never reach it.
  assign rom_addr = cpu.addr;
  assign rom_rd = cpu.rd && sel_rom;

  // ----------------------------------------------------------------------
  // Stack RAM and stack pointer
  // ----------------------------------------------------------------------
  assign sp_inc = r.sp + 5'h01;
  assign sp_dec = r.sp - 5'h01;

  // A push takes the write port over a CPU store in the same cycle.
  always_comb
  begin
    ram_wr_en = 1'b0;
    ram_wr_idx = cpu.addr[4:0];
    ram_wr_data = cpu.wdata;
    if (stack.push)
    begin
      ram_wr_en = 1'b1;
      ram_wr_idx = r.sp;
      ram_wr_data = stack.wdata;
    end
    else if (cpu.wr && sel_ram)
      ram_wr_en = 1'b1;
  end

  stack_ram #(
    .BYTES(memory_map_pkg::RAM_BYTES),
    .IDX_W(memory_map_pkg::SP_W)
  ) u_ram (
    .mclk(mclk),
    .wr_en(ram_wr_en),
    .wr_idx(ram_wr_idx),
    .wr_data(ram_wr_data),
    .rd_idx_a(cpu.addr[4:0]),
    .rd_data_a(ram_cpu_rdata),
    .rd_idx_b(sp_inc),
    .rd_data_b(ram_stk_rdata)
  );

  // ----------------------------------------------------------------------
  // I/O read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    io_rdata = memory_map_pkg::ZERO_BYTE;
    case (cpu.addr)
      memory_map_pkg::OFF_PORT_A_DATA:
        io_rdata = pin_view(port_a_data, r.port_a_direction,
                            port_a_pin_i);
      memory_map_pkg::OFF_PORT_B_DATA:
        io_rdata = pin_view({6'h00, port_b_data},
                            {6'h00, r.port_b_direction},
                            {6'h00, port_b_pin_i});
      memory_map_pkg::OFF_PORT_A_DIR:
        io_rdata = r.port_a_direction;
      memory_map_pkg::OFF_PORT_B_DIR:
        io_rdata = {6'h00, r.port_b_direction};
      memory_map_pkg::OFF_TIMER_SC:
      begin
        io_rdata[memory_map_pkg::TSC_OVF_FLAG] = r.overflow_flag;
        io_rdata[memory_map_pkg::TSC_PER_FLAG] = r.periodic_irq_flag;
        io_rdata[memory_map_pkg::TSC_OVF_IE] = r.overflow_irq_enable;
        io_rdata[memory_map_pkg::TSC_PER_IE] = r.periodic_irq_enable;
        io_rdata[memory_map_pkg::TSC_RATE_HI] = r.rate_select[1];
        io_rdata[memory_map_pkg::TSC_RATE_LO] = r.rate_select[0];
      end
      memory_map_pkg::OFF_TIMER_COUNT:
        io_rdata = r.timer_count_value;
      memory_map_pkg::OFF_EXT_IRQ_SC:
      begin
        io_rdata[memory_map_pkg::ISC_ENABLE] = r.ext_irq_enable;
        io_rdata[memory_map_pkg::ISC_FLAG] = r.ext_irq_flag;
      end
      default:
        io_rdata = memory_map_pkg::ZERO_BYTE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.watchdog_clear = 1'b0;
    next_r.timer_count_value = timer_count_in;

    if (io_wr)
    begin
      case (cpu.addr)
        memory_map_pkg::OFF_PORT_A_DIR:
          next_r.port_a_direction = cpu.wdata;
        memory_map_pkg::OFF_PORT_B_DIR:
          next_r.port_b_direction = cpu.wdata[1:0];
        memory_map_pkg::OFF_TIMER_SC:
        begin
          next_r.overflow_irq_enable =
            cpu.wdata[memory_map_pkg::TSC_OVF_IE];
          next_r.periodic_irq_enable =
            cpu.wdata[memory_map_pkg::TSC_PER_IE];
          next_r.rate_select = {cpu.wdata[memory_map_pkg::TSC_RATE_HI],
                                cpu.wdata[memory_map_pkg::TSC_RATE_LO]};
          if (cpu.wdata[memory_map_pkg::TSC_OVF_CLR])
            next_r.overflow_flag = 1'b0;
          if (cpu.wdata[memory_map_pkg::TSC_PER_CLR])
            next_r.periodic_irq_flag = 1'b0;
        end
        memory_map_pkg::OFF_EXT_IRQ_SC:
        begin
          next_r.ext_irq_enable = cpu.wdata[memory_map_pkg::ISC_ENABLE];
          if (cpu.wdata[memory_map_pkg::ISC_CLR])
            next_r.ext_irq_flag = 1'b0;
        end
        default:
          next_r.watchdog_clear = 1'b0;
      endcase
    end

    // Events are applied after clears so a coincident event is kept.
    if (timer_overflow_evt)
      next_r.overflow_flag = 1'b1;
    if (periodic_evt)
      next_r.periodic_irq_flag = 1'b1;
    if (ext_irq_evt)
      next_r.ext_irq_flag = 1'b1;

    if (cpu.wr && wdog_hit)
      next_r.watchdog_clear = 1'b1;

    if (stack.reset_sp)
      next_r.sp = memory_map_pkg::SP_RESET;
    else if (stack.push)
      next_r.sp = sp_dec;
    else if (stack.pull)
    begin
      next_r.sp = sp_inc;
      next_r.stack_rdata = ram_stk_rdata;
    end

    if (cpu.rd)
    begin
      if (sel_io)
        next_r.rdata = io_rdata;
      else if (sel_ram)
        next_r.rdata = ram_cpu_rdata;
      else if (sel_rom)
        next_r.rdata = rom_rdata;
      else
        next_r.rdata = memory_map_pkg::ZERO_BYTE;
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.rate_select <= memory_map_pkg::RATE_RESET;
      r.ext_irq_enable <= memory_map_pkg::EXT_EN_RESET;
      r.sp <= memory_map_pkg::SP_RESET;
    end
    else
      r <= next_r;
  end

  // Pin latches keep their value through reset, so they sit apart from
  // the reset state; pins stay safe because directions clear to input.
  always_ff @(posedge mclk)
  begin
    if (wr_port_a)
      port_a_data <= cpu.wdata;
    if (wr_port_b)
      port_b_data <= cpu.wdata[1:0];
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign cpu_rdata = r.rdata;
  assign stack_rdata = r.stack_rdata;
  assign stack_pointer = memory_map_pkg::RAM_BASE | {5'h00, r.sp};
  assign port_a_pin_o = port_a_data;
  assign port_a_pin_oe = r.port_a_direction;
  assign port_b_pin_o = port_b_data;
  assign port_b_pin_oe = r.port_b_direction;
  assign overflow_flag = r.overflow_flag;
  assign periodic_irq_flag = r.periodic_irq_flag;
  assign overflow_irq_enable = r.overflow_irq_enable;
  assign periodic_irq_enable = r.periodic_irq_enable;
  assign rate_select = r.rate_select;
  assign ext_irq_enable = r.ext_irq_enable;
  assign ext_irq_flag = r.ext_irq_flag;
  assign watchdog_clear = r.watchdog_clear;

endmodule

//--- verif/memory_map_io_decode_properties.sv
// Port-level assertions for the memory map decoder.
// Assumes the single mclk domain and the asynchronous active-high rst.
module memory_map_io_decode_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire memory_map_pkg::cpu_req_t cpu,
  input wire logic [7:0] cpu_rdata,
  input wire logic rom_rd,
  input wire logic [7:0] rom_rdata,
  input wire memory_map_pkg::stack_req_t stack,
  input wire logic [9:0] stack_pointer,
  input wire logic [7:0] port_a_pin_oe,
  input wire logic timer_overflow_evt,
  input wire logic ext_irq_evt,
  input wire logic overflow_flag,
  input wire logic ext_irq_flag,
  input wire logic watchdog_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic [9:0] a;
  logic io_gap;
  logic rom_hit;
  assign a = cpu.addr;
  assign io_gap = (a inside {10'h002, 10'h003, 10'h006, 10'h007})
    || (a >= 10'h00b && a <= 10'h01f);
  // The page-zero RAM window sits inside program space and must not leak.
  assign rom_hit = (a >= 10'h020 && a <= 10'h3ef
    && !(a >= 10'h0e0 && a <= 10'h0ff)) || a == 10'h3f0 || a >= 10'h3f8;
  sequence s_wdog_wr;
    cpu.wr && a == 10'h3f0;
  endsequence
  a_wdog_fires: assert property (s_wdog_wr |=> watchdog_clear)
    else $error("watchdog clear missing after its write");
  a_wdog_cause: assert property (watchdog_clear |-> $past(cpu.wr)
    && $past(a) == 10'h3f0) else $error("stray watchdog clear");
  a_rom_select: assert property (rom_rd == (cpu.rd && rom_hit))
    else $error("program memory select wrong");
  a_rom_data: assert property (cpu.rd && rom_rd |=>
    cpu_rdata == $past(rom_rdata)) else $error("program byte not returned");
  a_gap_zero: assert property (cpu.rd && io_gap |=>
    cpu_rdata == 8'h00) else $error("unimplemented address read nonzero");
  a_sp_push: assert property (stack.push && !stack.reset_sp |=>
    stack_pointer[4:0] == $past(stack_pointer[4:0]) - 5'h01)
    else $error("push did not decrement pointer");
  a_sp_pull: assert property (stack.pull && !stack.push &&
    !stack.reset_sp |=> stack_pointer[4:0] ==
    $past(stack_pointer[4:0]) + 5'h01) else $error("pull did not increment");
  a_sp_page: assert property (stack_pointer[9:5] == 5'h07)
    else $error("stack pointer left the RAM page");
  a_dir_write: assert property (cpu.wr && a == 10'h004 |=>
    port_a_pin_oe == $past(cpu.wdata)) else $error("direction A not written");
  a_ovf_set: assert property (timer_overflow_evt |=> overflow_flag)
    else $error("overflow flag not set");
  a_ovf_clear: assert property (cpu.wr && a == 10'h008 && cpu.wdata[3]
    && !timer_overflow_evt |=> !overflow_flag) else $error("flag not cleared");
  a_ext_set: assert property (ext_irq_evt |=> ext_irq_flag)
    else $error("external request flag not set");
endmodule

//--- verif/cpu_model.sv
// CPU side of the decoder: memory cycles and stack traffic.
// Assumes every task is entered just after a rising mclk edge.
module cpu_model (
  input wire logic mclk,
  input wire logic [7:0] cpu_rdata,
  input wire logic [7:0] stack_rdata,
  output memory_map_pkg::cpu_req_t cpu,
  output memory_map_pkg::stack_req_t stack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cpu = '0;
    stack = '0;
  end
  // Registers and memory take the very same cycle; no separate I/O kind.
  task automatic acc(input logic w, input logic [9:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    cpu = '{addr: a, rd: !w, wr: w, wdata: d};
    @(posedge mclk);
    #1;
    q = cpu_rdata;
  endtask
  // Released lines show inverted values so stale data cannot pass.
  task automatic idle();
    cpu = '{addr: ~cpu.addr, rd: 1'b0, wr: 1'b0, wdata: ~cpu.wdata};
    stack = '{push: 1'b0, pull: 1'b0, reset_sp: 1'b0, wdata: ~stack.wdata};
    @(posedge mclk);
    #1;
  endtask
  task automatic stk(input logic p, input logic [7:0] d,
                     output logic [7:0] q);
    stack = '{push: p, pull: !p, reset_sp: 1'b0, wdata: d};
    @(posedge mclk);
    #1;
    q = stack_rdata;
  endtask
  // A call stores two bytes and an interrupt entry five.
  task automatic push_n(input int n, input logic [7:0] base);
    logic [7:0] q;
    for (int i = 0; i < n; i++)
      stk(1'b1, base + 8'(i), q);
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the memory map decoder.
// Assumes the CPU model drives all requests and this bench models ROM.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, rom_rd, timer_overflow_evt, periodic_evt, ext_irq_evt;
  logic overflow_flag, periodic_irq_flag, overflow_irq_enable;
  logic periodic_irq_enable, ext_irq_enable, ext_irq_flag, watchdog_clear;
  logic [7:0] cpu_rdata, rom_rdata, stack_rdata, port_a_pin_i, port_a_pin_o;
  logic [7:0] port_a_pin_oe, timer_count_in, q, d;
  logic [9:0] rom_addr, stack_pointer, a;
  logic [1:0] port_b_pin_i, port_b_pin_o, port_b_pin_oe, rate_select;
  memory_map_pkg::cpu_req_t cpu;
  memory_map_pkg::stack_req_t stack;
  logic [31:0] seed = 32'h1e7c;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  memory_map_io_decode i_dut (.mclk, .rst, .cpu, .cpu_rdata, .rom_addr,
    .rom_rd, .rom_rdata, .stack, .stack_pointer, .stack_rdata,
    .port_a_pin_i, .port_a_pin_o, .port_a_pin_oe, .port_b_pin_i,
    .port_b_pin_o, .port_b_pin_oe, .timer_count_in, .timer_overflow_evt,
    .periodic_evt, .ext_irq_evt, .overflow_flag, .periodic_irq_flag,
    .overflow_irq_enable, .periodic_irq_enable, .rate_select,
    .ext_irq_enable, .ext_irq_flag, .watchdog_clear);
  cpu_model m (.mclk, .cpu_rdata, .stack_rdata, .cpu, .stack);
  function automatic logic [7:0] rom_fn(input logic [9:0] x);
    return x[7:0] ^ {x[9:8], 6'h2d};
  endfunction
  // Program memory answers at once and shows a changing pattern when idle.
  assign rom_rdata = rom_rd ? rom_fn(rom_addr) : ~rom_fn(rom_addr);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [9:0] x, input logic [7:0] e);
    logic [7:0] r;
    m.acc(1'b0, x, 8'h00, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [9:0] x, input logic [7:0] v);
    logic [7:0] r;
    m.acc(1'b1, x, v, r);
  endtask
  task test_done;
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      test_done;
    end
  end
  initial
  begin
    rst = 1'b1;
    {timer_overflow_evt, periodic_evt, ext_irq_evt} = 3'h0;
    port_a_pin_i = 8'(rnd());
    port_b_pin_i = 2'(rnd());
    timer_count_in = 8'h00;
    d = 8'(rnd());
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    rd(10'h004, 8'h00);
    rd(10'h005, 8'h00);
    rd(10'h008, 8'h03);
    rd(10'h009, 8'h00);
    rd(10'h00a, 8'h80);
    wr(10'h004, d);
    rd(10'h004, d);
    wr(10'h004, 8'hff);
    wr(10'h000, d);
    rd(10'h000, d);
    chk(port_a_pin_o, d);
    wr(10'h004, 8'h00);
    rd(10'h000, port_a_pin_i);
    wr(10'h005, 8'hff);
    rd(10'h005, 8'h03);
    wr(10'h001, 8'hfe);
    rd(10'h001, 8'h02);
    chk({6'h00, port_b_pin_oe, port_b_pin_o}, 10'h00e);
    wr(10'h005, 8'h00);
    rd(10'h001, {6'h00, port_b_pin_i});
    m.idle();
    rst = 1'b1;
    m.idle();
    rst = 1'b0;
    chk(port_a_pin_oe, 8'h00);
    wr(10'h004, 8'hff);
    rd(10'h000, d);
    for (int i = 2; i < 32; i++)
      if (!(i inside {4, 5, 8, 9, 10}))
      begin
        wr(10'(i), 8'hff);
        rd(10'(i), 8'h00);
      end
    rd(10'h004, 8'hff);
    timer_count_in = 8'(rnd());
    wr(10'h009, ~timer_count_in);
    rd(10'h009, timer_count_in);
    wr(10'h008, 8'h3e);
    rd(10'h008, 8'h32);
    chk({overflow_irq_enable, periodic_irq_enable, rate_select}, 10'h00e);
    m.idle();
    {timer_overflow_evt, periodic_evt, ext_irq_evt} = 3'h7;
    m.idle();
    {timer_overflow_evt, periodic_evt, ext_irq_evt} = 3'h0;
    rd(10'h008, 8'hf2);
    rd(10'h00a, 8'h88);
    chk({periodic_irq_flag, ext_irq_flag, ext_irq_enable}, 10'h007);
    wr(10'h008, 8'h3a);
    rd(10'h008, 8'h72);
    wr(10'h008, 8'h37);
    rd(10'h008, 8'h33);
    wr(10'h00a, 8'h02);
    rd(10'h00a, 8'h00);
    ext_irq_evt = 1'b1;
    wr(10'h00a, 8'h82);
    ext_irq_evt = 1'b0;
    rd(10'h00a, 8'h88);
    repeat (20)
    begin
      a = 10'h020 + 10'(rnd() % 976);
      if (a >= 10'h0e0 && a <= 10'h0ff)
        a = a + 10'h020;
      rd(a, rom_fn(a));
    end
    for (int i = 32'h3f8; i < 32'h400; i++)
      rd(10'(i), rom_fn(10'(i)));
    rd(10'h3f1, 8'h00);
    wr(10'h3f0, 8'h01);
    chk(watchdog_clear, 1'b1);
    rd(10'h3f0, rom_fn(10'h3f0));
    chk(rom_addr, 10'h3f0);
    chk(watchdog_clear, 1'b0);
    for (int i = 0; i < 32; i++)
      wr(10'h0e0 + 10'(i), 8'(i * 7 + 3));
    for (int i = 0; i < 32; i++)
      rd(10'h0e0 + 10'(i), 8'(i * 7 + 3));
    m.idle();
    m.push_n(2, 8'h40);
    chk(stack_pointer, 10'h0fd);
    m.push_n(5, 8'h50);
    chk(stack_pointer, 10'h0f8);
    for (int i = 6; i >= 0; i--)
    begin
      m.stk(1'b0, 8'h00, q);
      chk(q, i > 1 ? 8'h4e + 8'(i) : 8'h40 + 8'(i));
    end
    chk(stack_pointer, 10'h0ff);
    m.idle();
    rd(10'h0ff, 8'h40);
    m.idle();
    test_done;
  end
endmodule
bind memory_map_io_decode memory_map_io_decode_properties i_props (.mclk,
  .rst, .cpu, .cpu_rdata, .rom_rd, .rom_rdata, .stack, .stack_pointer,
  .port_a_pin_oe, .timer_overflow_evt, .ext_irq_evt, .overflow_flag,
  .ext_irq_flag, .watchdog_clear);
